// ---- pkg/eil_pkg.sv ----
//Contract
//- A low on the dedicated request pin can set the request latch.
//- A vector fetch acknowledges and clears the latch per sensitivity.
//- Writing one to the acknowledge bit acts like a vector fetch.
//- Reset clears the latch and sensitivity bit even with pin low.
//- Sensitivity bit set: edges and low levels; clear: falling edges only.
//- Edge-only: request holds until fetch, acknowledge or reset, then clears at once.
//- Edge-level: clears only after acknowledge and pin high, any order.
//- A falling edge after an acknowledge sets the latch again.
//- Mask withholds the request from the CPU but keeps the latch.
//- An unmasked request makes the CPU fetch the vector pair FFF8/FFF9.
//- Pending flag reads the latch, independent of the mask.
//- Shared pin is a source only when USB is off and its enable is one.
//- Shared pin enable forces that pin to input with its pullup on.
//- Shared pin source is ORed with the dedicated pin into one latch.
//- A shared pin event sets the shared pin flag.
//- In break with break-clear enable zero, acknowledge writes do nothing.
//- With break-clear enable one, break acknowledges clear and stay cleared.
//- Dedicated pin pullup stays on unless pullup disable bit is set.
//- Acknowledge bit is write-only, reads zero, cleared by reset.
//- Shared pin flag is read-only and clears when option register is read.
//- Mask bit one disables requests; reset clears it.
package eil_pkg;
   localparam int           ADDR_W       = 8;
   localparam int           DATA_W       = 8;
   localparam logic [7:0]   ADDR_OPTION  = 8'h1C;
   localparam logic [7:0]   ADDR_STATUS  = 8'h1D;
   localparam logic [15:0]  VECTOR_ADDR  = 16'hFFF8;
   localparam int           BIT_MODE     = 0;
   localparam int           BIT_MASK     = 1;
   localparam int           BIT_ACK      = 2;
   localparam int           BIT_PEND     = 3;
   localparam int           BIT_PULLDIS  = 0;
   localparam int           BIT_SH_EN    = 1;
   localparam int           BIT_SH_FLAG  = 2;

   typedef struct packed {
      logic [1:0] irq_sync;
      logic [1:0] sh_sync;
      logic       irq_prev;
      logic       sh_prev;
      logic       latch;
      logic       mode;
      logic       mask;
      logic       pull_dis;
      logic       sh_en;
      logic       sh_flag;
      logic       ack_seen;
      logic [7:0] rdata;
      logic       req;
      logic       irq_pull;
      logic       sh_pull;
      logic       sh_oe_n;
   } eil_state_t;
endpackage : eil_pkg

// ---- src/eil_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module eil_unit (
   input  wire logic       sys_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       clk_en_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   input  wire logic       irq_pin_n_in,
   input  wire logic       shared_port_pin_in,
   input  wire logic       usb_function_on_in,
   input  wire logic       break_state_in,
   input  wire logic       break_clear_enable_in,
   input  wire logic       vector_fetch_in,
   output logic            cpu_request_out,
   output logic            irq_pullup_on_out,
   output logic            shared_pullup_on_out,
   output logic            shared_pin_oe_n_out
);
   eil_pkg::eil_state_t s_q, s_d;
   logic irq_s;
   logic sh_s;
   logic sh_act;
   logic in_now;
   logic in_prev;
   logic fall;
   logic ack;
   logic soft_ack;
   logic wr_st;
   logic wr_op;
   logic rd_op;

   always_comb begin
      s_d      = s_q;
      irq_s    = s_q.irq_sync[1];
      sh_s     = s_q.sh_sync[1];
      wr_st    = wr_in && (addr_in == eil_pkg::ADDR_STATUS);
      wr_op    = wr_in && (addr_in == eil_pkg::ADDR_OPTION);
      rd_op    = rd_in && (addr_in == eil_pkg::ADDR_OPTION);
      sh_act   = s_q.sh_en && !usb_function_on_in;
      // Combined active-low input: while sh_act is set, shared pin low also pulls it low.
      in_now   = irq_s && !(sh_act && !sh_s);
      in_prev  = s_q.irq_prev && !(sh_act && !s_q.sh_prev);
      fall     = in_prev && !in_now;
      soft_ack = wr_st && wdata_in[eil_pkg::BIT_ACK]
                 && (!break_state_in || break_clear_enable_in);
      ack      = vector_fetch_in || soft_ack;
      s_d.irq_sync = {s_q.irq_sync[0], irq_pin_n_in};
      s_d.sh_sync  = {s_q.sh_sync[0], shared_port_pin_in};
      s_d.irq_prev = irq_s;
      s_d.sh_prev  = sh_s;
      // In level mode an acknowledge taken while the pin is still low is remembered,
      // so that the latch clears as soon as the pin returns high.
      if (s_q.mode) begin
         if ((ack || s_q.ack_seen) && in_now) begin
            s_d.latch    = 1'b0;
            s_d.ack_seen = 1'b0;
         end else if (ack) begin
            s_d.ack_seen = 1'b1;
         end
      end else begin
         s_d.ack_seen = 1'b0;
         if (ack) begin
            s_d.latch = 1'b0;
         end
      end
      if (fall || (s_q.mode && !in_now)) begin
         s_d.latch = 1'b1;
      end
      if (wr_st) begin
         s_d.mode = wdata_in[eil_pkg::BIT_MODE];
         s_d.mask = wdata_in[eil_pkg::BIT_MASK];
      end
      if (wr_op) begin
         s_d.pull_dis = wdata_in[eil_pkg::BIT_PULLDIS];
         s_d.sh_en    = wdata_in[eil_pkg::BIT_SH_EN];
      end
      if (rd_op) begin
         s_d.sh_flag = 1'b0;
      end
      if (sh_act && s_q.sh_prev && !sh_s) begin
         s_d.sh_flag = 1'b1;
      end
      s_d.rdata = 8'h00;
      if (rd_in && addr_in == eil_pkg::ADDR_STATUS) begin
         s_d.rdata[eil_pkg::BIT_MODE] = s_q.mode;
         s_d.rdata[eil_pkg::BIT_MASK] = s_q.mask;
         s_d.rdata[eil_pkg::BIT_PEND] = s_q.latch;
      end else if (rd_op) begin
         s_d.rdata[eil_pkg::BIT_PULLDIS] = s_q.pull_dis;
         s_d.rdata[eil_pkg::BIT_SH_EN]   = s_q.sh_en;
         s_d.rdata[eil_pkg::BIT_SH_FLAG] = s_q.sh_flag;
      end
      s_d.req      = s_d.latch && !s_d.mask;
      s_d.irq_pull = !s_d.pull_dis;
      s_d.sh_pull  = s_d.sh_en;
      s_d.sh_oe_n  = 1'b1;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         // Synchronisers and previous samples reset low, so a pin held low through
         // reset is never mistaken for a falling edge after release.
         s_q          <= '0;
         s_q.irq_pull <= 1'b1;
         s_q.sh_oe_n  <= 1'b1;
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end

   assign rdata_out            = s_q.rdata;
   assign cpu_request_out      = s_q.req;
   assign irq_pullup_on_out    = s_q.irq_pull;
   assign shared_pullup_on_out = s_q.sh_pull;
   assign shared_pin_oe_n_out  = s_q.sh_oe_n;

   a_mask_blocks_req: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      s_q.mask |-> !cpu_request_out) else $error("request leaked through mask");
   a_edge_sets_latch: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && fall |=> s_q.latch) else $error("edge did not set latch");
   a_edge_ack_clears: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && !s_q.mode && ack && !fall |=> !s_q.latch) else $error("ack did not clear");
   a_level_holds: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && s_q.mode && !in_now |=> s_q.latch) else $error("level lost");
   a_break_protects: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && s_q.latch && break_state_in && !break_clear_enable_in && !vector_fetch_in
      |=> s_q.latch) else $error("break ack cleared latch");
   a_flag_read_clr: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && rd_op && !(sh_act && s_q.sh_prev && !sh_s) |=> !s_q.sh_flag)
      else $error("flag not cleared by read");
   a_pend_readback: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && rd_in && addr_in == eil_pkg::ADDR_STATUS
      |=> rdata_out[eil_pkg::BIT_PEND] == $past(s_q.latch) && !rdata_out[eil_pkg::BIT_ACK])
      else $error("pending readback wrong");
   a_pullup_follow: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in |=> irq_pullup_on_out == !s_q.pull_dis) else $error("pullup mismatch");
   a_level_ack_clears: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && s_q.mode && (ack || s_q.ack_seen) && in_now |=> !s_q.latch)
      else $error("level ack did not clear");
   a_level_ack_kept: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && s_q.mode && ack && !in_now |=> s_q.ack_seen)
      else $error("level ack forgotten");
   a_shared_input: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in |=> shared_pin_oe_n_out) else $error("shared pin driven");
endmodule : eil_unit
`default_nettype wire

// ---- bench/eil_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eil_cpu_model #(parameter int DELAY = 3) (
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   input  wire logic enable_in,
   input  wire logic request_in,
   output logic      fetch_out
);
   logic [3:0] wait_q;
   // A vector fetch follows a request; the !fetch_out guard keeps a lagging request from a second fetch.
   always_ff @(posedge sys_clk_in) begin
      fetch_out <= 1'b0;
      wait_q    <= 4'h0;
      if (reset_n_in && request_in && enable_in && !fetch_out) begin
         wait_q <= wait_q + 4'h1;
         if (wait_q == 4'(DELAY)) begin
            fetch_out <= 1'b1;
            wait_q    <= 4'h0;
         end
      end
   end
endmodule : eil_cpu_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, irq_n = 1, sh = 1, brk = 0, bce = 0, en = 0, fetch, req, pu, spu, oe_n;
   logic [7:0] a = 8'h00, wd = 8'h00, rdat;
   int err_count = 0, n_tests = 0;
   always #10 clk = ~clk;
   eil_unit uut (.sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1), .addr_in(a), .wdata_in(wd), .wr_in(wr),
      .rd_in(rd), .rdata_out(rdat), .irq_pin_n_in(irq_n), .shared_port_pin_in(sh), .usb_function_on_in(1'b0),
      .break_state_in(brk), .break_clear_enable_in(bce), .vector_fetch_in(fetch), .cpu_request_out(req),
      .irq_pullup_on_out(pu), .shared_pullup_on_out(spu), .shared_pin_oe_n_out(oe_n));
   eil_cpu_model cpu (.sys_clk_in(clk), .reset_n_in(rst_n), .enable_in(en), .request_in(req), .fetch_out(fetch));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n); repeat (n) @(posedge clk); endtask : cyc
   task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk) begin wr <= 1; a <= ad; wd <= d; end
      @(posedge clk) wr <= 0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clk) begin rd <= 1; a <= ad; end
      @(posedge clk) rd <= 0;
      #1 chk("rdata", exp, rdat);
   endtask : rd_reg
   task automatic fall(input bit shared);
      @(posedge clk) if (shared) sh <= 0; else irq_n <= 0;
      cyc(3);
      sh <= 1;
      irq_n <= 1;
      cyc(6);
   endtask : fall
   task automatic t_reset;
      chk("pullup", 8'h01, {7'h00, pu});
      chk("oe_n", 8'h01, {7'h00, oe_n});
      rd_reg(8'h1D, 8'h00);
      rd_reg(8'h1C, 8'h00);
   endtask : t_reset
   task automatic t_edge;
      wr_reg(8'h1D, 8'h02);
      fall(0);
      chk("request", 8'h00, {7'h00, req});
      rd_reg(8'h1D, 8'h0A);
      wr_reg(8'h1D, 8'h06);
      rd_reg(8'h1D, 8'h02);
      fall(0);
      rd_reg(8'h1D, 8'h0A);
      wr_reg(8'h1D, 8'h06);
   endtask : t_edge
   task automatic t_level;
      wr_reg(8'h1D, 8'h03);
      @(posedge clk) irq_n <= 0;
      cyc(6);
      wr_reg(8'h1D, 8'h07);
      cyc(3);
      rd_reg(8'h1D, 8'h0B);
      @(posedge clk) irq_n <= 1;
      cyc(6);
      rd_reg(8'h1D, 8'h03);
   endtask : t_level
   task automatic t_break;
      wr_reg(8'h1D, 8'h02);
      fall(0);
      @(posedge clk) brk <= 1;
      wr_reg(8'h1D, 8'h06);
      rd_reg(8'h1D, 8'h0A);
      @(posedge clk) bce <= 1;
      wr_reg(8'h1D, 8'h06);
      @(posedge clk) begin brk <= 0; bce <= 0; end
      rd_reg(8'h1D, 8'h02);
   endtask : t_break
   task automatic t_shared;
      wr_reg(8'h1C, 8'h02);
      cyc(2);
      chk("shared pullup", 8'h01, {7'h00, spu});
      fall(1);
      rd_reg(8'h1C, 8'h06);
      rd_reg(8'h1C, 8'h02);
      rd_reg(8'h1D, 8'h0A);
      wr_reg(8'h1D, 8'h06);
   endtask : t_shared
   task automatic t_vector;
      wr_reg(8'h1D, 8'h00);
      fall(0);
      chk("request", 8'h01, {7'h00, req});
      @(posedge clk) en <= 1;
      cyc(10);
      rd_reg(8'h1D, 8'h00);
      @(posedge clk) en <= 0;
   endtask : t_vector
   task automatic t_reset_mid;
      wr_reg(8'h1D, 8'h01);
      @(posedge clk) irq_n <= 0;
      cyc(6);
      chk("request", 8'h01, {7'h00, req});
      @(posedge clk) rst_n <= 0;
      cyc(2);
      rst_n <= 1;
      cyc(4);
      chk("request", 8'h00, {7'h00, req});
      rd_reg(8'h1D, 8'h00);
      @(posedge clk) irq_n <= 1;
      cyc(4);
      rd_reg(8'h1D, 8'h00);
   endtask : t_reset_mid
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000 err_count++;
      tally_and_finish();
   end
   initial begin
      cyc(5);
      rst_n <= 1;
      t_reset();
      t_edge();
      t_level();
      t_break();
      t_shared();
      t_vector();
      t_reset_mid();
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
